/* verilog/ocd_pkg.sv */
package ocd_pkg;

    // Levels in tenths of a percent of rated current, periods in ms
    localparam int unsigned OCD_CLK_HZ        = 25_000_000;
    localparam int unsigned OCD_MS_PER_S      = 1000;
    localparam int unsigned OCD_MS_CYCLES     = OCD_CLK_HZ / OCD_MS_PER_S;

    localparam int unsigned OCD_LEVEL_W       = 11;
    localparam int unsigned OCD_CUR_W         = 12;
    localparam int unsigned OCD_OC_PER_W      = 14;
    localparam int unsigned OCD_ZC_PER_W      = 10;
    localparam int unsigned OCD_HOLD_W        = 7;

    localparam logic [10:0] OCD_LEVEL_MAX     = 11'h7d0;
    localparam logic [10:0] OCD_OC_LEVEL_DEF  = 11'h5dc;
    localparam logic [10:0] OCD_ZC_LEVEL_DEF  = 11'h032;

    localparam logic [13:0] OCD_OC_PER_MAX    = 14'h2710;
    localparam logic [13:0] OCD_OC_PER_DEF    = 14'h0000;
    localparam logic [9:0]  OCD_ZC_PER_MAX    = 10'h3e8;
    localparam logic [9:0]  OCD_ZC_PER_DEF    = 10'h1f4;
    localparam logic [9:0]  OCD_ZC_PER_SHORT  = 10'h028;

    localparam logic [13:0] OCD_OC_MIN_MS     = 14'h0032;
    localparam logic [9:0]  OCD_ZC_MIN_MS     = 10'h032;
    localparam logic [6:0]  OCD_HOLD_MS       = 7'h64;

    // Terminal function codes
    localparam logic [1:0]  OCD_SEL_NONE      = 2'h0;
    localparam logic [1:0]  OCD_SEL_OC        = 2'h1;
    localparam logic [1:0]  OCD_SEL_ZC        = 2'h2;

endpackage : ocd_pkg

/* verilog/ocd_detect.sv */
// How it works
// RULE1: While running, flag overcurrent after current stays above level longer than period.
// RULE2: Overcurrent level spans 0 to 200.0 percent of rated current, default 150.
// RULE3: Overcurrent period spans 0 to 10 s, default 0, timed from level crossing.
// RULE4: Overcurrent flag stays on at least 100 ms once it turns on.
// RULE5: Overcurrent detector also works during online or offline motor tuning.
// RULE6: Overcurrent period of zero still qualifies for about 50 ms.
// RULE7: While running, flag zero current after current stays below level longer than period.
// RULE8: Zero level spans 0 to 200.0 percent of rated current, default 5.0.
// RULE9: Zero period spans 0 to 1 s, default 0.5 s, timed from dropping below.
// RULE10: Zero current flag lingers about 100 ms after current rises back above level.
// RULE11: Zero current detector also works during online motor tuning.
// RULE12: Zero period of 0 to 0.04 s qualifies for about 50 ms.
// RULE13: Each flag drives whichever output terminal selects its function.
// RULE14: Both qualification timers clear while the drive is not running; here each keeps counting during tuning that enables its detector.
`timescale 1ns/10ps

module ocd_detect
    import ocd_pkg::*;
#(
    parameter int unsigned MS_CYCLES = OCD_MS_CYCLES,
    parameter int unsigned N_TERM    = 4
)(
    // Clock and reset
    input  wire logic                     core_clk_in,
    input  wire logic                     rstn_in,
    // Drive status
    input  wire logic [OCD_CUR_W-1:0]     current_in,
    input  wire logic                     running_in,
    input  wire logic                     tune_online_in,
    input  wire logic                     tune_offline_in,
    // Settings
    input  wire logic [OCD_LEVEL_W-1:0]   overcurrent_level_setting_in,
    input  wire logic [OCD_OC_PER_W-1:0]  overcurrent_period_setting_in,
    input  wire logic [OCD_LEVEL_W-1:0]   zero_level_setting_in,
    input  wire logic [OCD_ZC_PER_W-1:0]  zero_period_setting_in,
    input  wire logic [2*N_TERM-1:0]      term_func_sel_in,
    // Flags and terminals
    output logic                          overcurrent_detect_flag_out,
    output logic                          zero_current_flag_out,
    output logic [N_TERM-1:0]             term_on_out
);

    localparam int unsigned DIV_W = $clog2(MS_CYCLES + 1);

    typedef struct packed {
        logic [DIV_W-1:0]         ms_div;
        logic [OCD_OC_PER_W-1:0]  oc_cnt;
        logic [OCD_HOLD_W-1:0]    oc_hold;
        logic                     oc_flag;
        logic [OCD_ZC_PER_W-1:0]  zc_cnt;
        logic [OCD_HOLD_W-1:0]    zc_hold;
        logic                     zc_flag;
        logic [N_TERM-1:0]        term;
    } ocd_state_type;

    ocd_state_type r;
    ocd_state_type nxt;

    // Out-of-range settings saturate rather than wrap
    function automatic logic [OCD_LEVEL_W-1:0] clamp_level(input logic [OCD_LEVEL_W-1:0] lvl);
        clamp_level = (lvl > OCD_LEVEL_MAX) ? OCD_LEVEL_MAX : lvl;
    endfunction : clamp_level

    function automatic logic select_flag(input logic [1:0] sel, input logic oc, input logic zc);
        select_flag = (sel == OCD_SEL_OC) ? oc : ((sel == OCD_SEL_ZC) ? zc : 1'b0);
    endfunction : select_flag

    logic [OCD_LEVEL_W-1:0]   oc_level;
    logic [OCD_LEVEL_W-1:0]   zc_level;
    logic [OCD_OC_PER_W-1:0]  oc_per;
    logic [OCD_ZC_PER_W-1:0]  zc_per;
    logic [OCD_OC_PER_W-1:0]  oc_eff;
    logic [OCD_ZC_PER_W-1:0]  zc_eff;
    logic                     oc_act;
    logic                     zc_act;
    logic                     oc_cond;
    logic                     zc_cond;
    logic                     ms_tick;

    always_comb
    begin
        oc_level = clamp_level(overcurrent_level_setting_in);               // RULE2
        zc_level = clamp_level(zero_level_setting_in);                      // RULE8
        oc_per   = (overcurrent_period_setting_in > OCD_OC_PER_MAX) ?
                   OCD_OC_PER_MAX : overcurrent_period_setting_in;          // RULE3
        zc_per   = (zero_period_setting_in > OCD_ZC_PER_MAX) ?
                   OCD_ZC_PER_MAX : zero_period_setting_in;                 // RULE9
        oc_eff   = (oc_per == '0) ? OCD_OC_MIN_MS : oc_per;                 // RULE6
        zc_eff   = (zc_per <= OCD_ZC_PER_SHORT) ? OCD_ZC_MIN_MS : zc_per;   // RULE12
        oc_act   = running_in | tune_online_in | tune_offline_in;           // RULE5
        zc_act   = running_in | tune_online_in;                             // RULE11
        oc_cond  = oc_act & (current_in > OCD_CUR_W'(oc_level));            // RULE1
        zc_cond  = zc_act & (current_in < OCD_CUR_W'(zc_level));            // RULE7
        ms_tick  = (r.ms_div == DIV_W'(MS_CYCLES - 1));
    end

    always_comb
    begin
        nxt        = r;
        nxt.ms_div = ms_tick ? '0 : r.ms_div + 1'b1;

        // Overcurrent qualification, counted in whole milliseconds
        if (!oc_cond)
        begin
            nxt.oc_cnt = '0;                                                // RULE14
        end
        else if (ms_tick && !r.oc_flag)
        begin
            if (r.oc_cnt >= oc_eff)
            begin
                nxt.oc_flag = 1'b1;                                         // RULE1
                nxt.oc_hold = OCD_HOLD_MS;                                  // RULE4
            end
            else
            begin
                nxt.oc_cnt = r.oc_cnt + 1'b1;                               // RULE3
            end
        end
        if (r.oc_flag)
        begin
            if (ms_tick && (r.oc_hold != '0))
            begin
                nxt.oc_hold = r.oc_hold - 1'b1;
            end
            if (!oc_cond && (r.oc_hold == '0))
            begin
                nxt.oc_flag = 1'b0;                                         // RULE4
                nxt.oc_cnt  = '0;
            end
        end

        // Zero current qualification; release delay restarts on each return
        if (!zc_cond)
        begin
            nxt.zc_cnt = '0;                                                // RULE14
        end
        else if (ms_tick && !r.zc_flag)
        begin
            if (r.zc_cnt >= zc_eff)
            begin
                nxt.zc_flag = 1'b1;                                         // RULE7
            end
            else
            begin
                nxt.zc_cnt = r.zc_cnt + 1'b1;                               // RULE9
            end
        end
        if (zc_cond)
        begin
            nxt.zc_hold = OCD_HOLD_MS;
        end
        else if (r.zc_flag && ms_tick)
        begin
            if (r.zc_hold <= OCD_HOLD_W'(1))
            begin
                nxt.zc_flag = 1'b0;                                         // RULE10
                nxt.zc_hold = '0;
            end
            else
            begin
                nxt.zc_hold = r.zc_hold - 1'b1;                             // RULE10
            end
        end

        for (int i = 0; i < N_TERM; i++)
        begin
            nxt.term[i] = select_flag(term_func_sel_in[2*i +: 2], nxt.oc_flag, nxt.zc_flag); // RULE13
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end

    assign overcurrent_detect_flag_out = r.oc_flag;
    assign zero_current_flag_out       = r.zc_flag;
    assign term_on_out                 = r.term;

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_oc_set;
        $rose(r.oc_flag) |-> $past(oc_cond) && $past(ms_tick);
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("overcurrent flag rose without qualified condition"); // RULE1

    property p_oc_range;
        (oc_level <= OCD_LEVEL_MAX) && (oc_per <= OCD_OC_PER_MAX);
    endproperty
    a_oc_range: assert property (p_oc_range) else $error("overcurrent setting out of range"); // RULE2

    property p_oc_period;
        $rose(r.oc_flag) |-> $past(r.oc_cnt) == $past(oc_eff);
    endproperty
    a_oc_period: assert property (p_oc_period) else $error("overcurrent flag rose before period"); // RULE3

    property p_oc_hold;
        $fell(r.oc_flag) |-> $past(r.oc_hold) == '0;
    endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag dropped early"); // RULE4

    property p_oc_keep;
        (r.oc_flag && (r.oc_hold != '0)) |=> r.oc_flag;
    endproperty
    a_oc_keep: assert property (p_oc_keep) else $error("overcurrent flag left during hold"); // RULE4

    property p_oc_drop;
        $fell(r.oc_flag) |-> !$past(oc_cond);
    endproperty
    a_oc_drop: assert property (p_oc_drop) else $error("overcurrent flag dropped while condition held"); // RULE4

    // Any break in the condition must restart qualification
    property p_oc_clear;
        (!oc_cond) |=> (r.oc_cnt == '0);
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("overcurrent timer kept across a break"); // RULE1

    property p_zc_clear;
        (!zc_cond) |=> (r.zc_cnt == '0);
    endproperty
    a_zc_clear: assert property (p_zc_clear) else $error("zero timer kept across a break"); // RULE7

    property p_zc_period;
        ($rose(r.zc_flag) && ($past(zc_per) > OCD_ZC_PER_SHORT)) |-> ($past(r.zc_cnt) == $past(zc_per));
    endproperty
    a_zc_period: assert property (p_zc_period) else $error("zero flag rose off its period"); // RULE9

    // Release only moves on millisecond ticks
    property p_zc_linger;
        (r.zc_flag && !ms_tick) |=> r.zc_flag;
    endproperty
    a_zc_linger: assert property (p_zc_linger) else $error("zero flag released between ticks"); // RULE10

    property p_zc_load;
        zc_cond |=> (r.zc_hold == OCD_HOLD_MS);
    endproperty
    a_zc_load: assert property (p_zc_load) else $error("zero release delay not restarted"); // RULE10

    property p_zc_stop;
        (!zc_act) |=> (r.zc_cnt == '0);
    endproperty
    a_zc_stop: assert property (p_zc_stop) else $error("zero timer kept across stop"); // RULE14

    property p_oc_tune;
        (tune_offline_in && oc_cond && ms_tick && !r.oc_flag && (r.oc_cnt < oc_eff)) |=> (r.oc_cnt != '0);
    endproperty
    a_oc_tune: assert property (p_oc_tune) else $error("overcurrent not timing during tuning"); // RULE5

    property p_oc_min;
        ($rose(r.oc_flag) && $past(oc_per) == '0) |-> $past(r.oc_cnt) == OCD_OC_MIN_MS;
    endproperty
    a_oc_min: assert property (p_oc_min) else $error("zero overcurrent period not about 50 ms"); // RULE6

    property p_zc_set;
        $rose(r.zc_flag) |-> $past(zc_cond) && ($past(r.zc_cnt) == $past(zc_eff));
    endproperty
    a_zc_set: assert property (p_zc_set) else $error("zero flag rose without qualified condition"); // RULE7

    property p_zc_range;
        (zc_level <= OCD_LEVEL_MAX) && (zc_per <= OCD_ZC_PER_MAX);
    endproperty
    a_zc_range: assert property (p_zc_range) else $error("zero setting out of range"); // RULE8

    property p_zc_release;
        $fell(r.zc_flag) |-> !$past(zc_cond) && ($past(r.zc_hold) == OCD_HOLD_W'(1));
    endproperty
    a_zc_release: assert property (p_zc_release) else $error("zero flag released early"); // RULE10

    property p_zc_tune;
        (tune_online_in && zc_cond && ms_tick && !r.zc_flag && (r.zc_cnt < zc_eff)) |=> (r.zc_cnt != '0);
    endproperty
    a_zc_tune: assert property (p_zc_tune) else $error("zero current not timing during tuning"); // RULE11

    property p_zc_min;
        ($rose(r.zc_flag) && $past(zc_per) <= OCD_ZC_PER_SHORT) |-> $past(r.zc_cnt) == OCD_ZC_MIN_MS;
    endproperty
    a_zc_min: assert property (p_zc_min) else $error("short zero period not about 50 ms"); // RULE12

    property p_stop_clear;
        (!oc_act) |=> (r.oc_cnt == '0) && (r.zc_cnt == '0);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("timers kept across stop"); // RULE14

    for (genvar g = 0; g < N_TERM; g++)
    begin : g_term
        property p_term;
            term_on_out[g] == select_flag(term_func_sel_in[2*g +: 2], r.oc_flag, r.zc_flag) || $changed(term_func_sel_in);
        endproperty
        a_term: assert property (p_term) else $error("terminal not following selected flag"); // RULE13
    end

    c_oc_on: cover property ($rose(r.oc_flag));
    c_oc_off: cover property ($fell(r.oc_flag));
    c_zc_on: cover property ($rose(r.zc_flag));
    c_zc_off: cover property ($fell(r.zc_flag));
    c_zc_tune: cover property (tune_online_in && $rose(r.zc_flag));

endmodule : ocd_detect

/* dv/ocd_drive_model.sv */
`timescale 1ns/10ps

module ocd_drive_model
    import ocd_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 rstn_in,
    // Commanded and sensed current
    input  wire logic [OCD_CUR_W-1:0] target_in,
    output logic      [OCD_CUR_W-1:0] current_out
);
    // Sensed value lags the command by one sample, as a real measurement path does
    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
            current_out <= '0;
        else
            current_out <= target_in;
    end
endmodule : ocd_drive_model

/* dv/tb_output_current_threshold_detect.sv */
`timescale 1ns/10ps

module tb_output_current_threshold_detect
    import ocd_pkg::*;
();
    localparam int MSC = 4;
    logic                    core_clk_in = 1'b0;
    logic                    rstn_in     = 1'b0;
    logic                    running     = 1'b0;
    logic                    ton         = 1'b0;
    logic                    toff        = 1'b0;
    logic [OCD_CUR_W-1:0]    target      = '0;
    logic [OCD_LEVEL_W-1:0]  oc_lvl      = OCD_OC_LEVEL_DEF;
    logic [OCD_OC_PER_W-1:0] oc_per      = OCD_OC_PER_DEF;
    logic [OCD_LEVEL_W-1:0]  zc_lvl      = OCD_ZC_LEVEL_DEF;
    logic [OCD_ZC_PER_W-1:0] zc_per      = OCD_ZC_PER_DEF;
    logic [7:0]              sel         = {2'h3, OCD_SEL_NONE, OCD_SEL_ZC, OCD_SEL_OC};
    wire  [OCD_CUR_W-1:0]    cur;
    logic                    oc_flag;
    logic                    zc_flag;
    logic [3:0]              term;
    int                      bad_count   = 0;
    int                      checks      = 0;
    int                      seed        = 51084;
    int                      lvl;

    always #20 core_clk_in = ~core_clk_in;

    ocd_drive_model drv (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .target_in(target), .current_out(cur));

    ocd_detect #(.MS_CYCLES(MSC), .N_TERM(4)) uut (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .current_in(cur), .running_in(running),
        .tune_online_in(ton), .tune_offline_in(toff), .overcurrent_level_setting_in(oc_lvl),
        .overcurrent_period_setting_in(oc_per), .zero_level_setting_in(zc_lvl),
        .zero_period_setting_in(zc_per), .term_func_sel_in(sel),
        .overcurrent_detect_flag_out(oc_flag), .zero_current_flag_out(zc_flag), .term_on_out(term));

    function automatic int eff_oc(input int p);
        return (p == 0) ? 50 : p;
    endfunction : eff_oc

    function automatic int eff_zc(input int p);
        return (p <= 40) ? 50 : p;
    endfunction : eff_zc

    task automatic check(input logic seen, input logic exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: flag, terminal or timing mismatch", $time);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // Waits for a flag to reach a level; the edge count must land in [lo, hi]
    task automatic wait_flag(input bit zc, input logic want, input int lo, input int hi);
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        while (((zc ? zc_flag : oc_flag) !== want) && n <= hi);
        check(n >= lo && n <= hi, 1'b1);
        check(term[0], oc_flag);
        check(term[1], zc_flag);
        check(term[3:2] == 2'h0, 1'b1);
        if (n > hi)
            test_done();
    endtask : wait_flag

    // Rise within the qualification window, then release about 100 ms later
    task automatic qualify(input bit zc, input int eff, input int on_cur, input int off_cur);
        @(posedge core_clk_in);
        target <= on_cur[OCD_CUR_W-1:0];
        wait_flag(zc, 1'b1, (eff - 1) * MSC, (eff + 2) * MSC + 2);
        @(posedge core_clk_in);
        target <= off_cur[OCD_CUR_W-1:0];
        wait_flag(zc, 1'b0, 99 * MSC, 102 * MSC);
    endtask : qualify

    initial
    begin
        repeat (8) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        running <= 1'b1;
        target  <= 12'h3e8;
        qualify(0, eff_oc(0), 1600, 1000);
        $display("test overcurrent default done");
        for (int i = 0; i < 3; i++)
        begin
            lvl = 100 + ($unsigned($random(seed)) % 1900);
            oc_lvl <= lvl[OCD_LEVEL_W-1:0];
            oc_per <= 14'(55 + ($unsigned($random(seed)) % 96));
            target <= lvl[OCD_CUR_W-1:0];
            repeat (20 * MSC) @(posedge core_clk_in);
            check(oc_flag, 1'b0);
            qualify(0, eff_oc(int'(oc_per)), lvl + 1, lvl);
        end
        $display("test overcurrent random done");
        oc_lvl <= 11'h7ff;
        oc_per <= 14'h0000;
        qualify(0, 50, 2001, 2000);
        oc_lvl <= OCD_OC_LEVEL_DEF;
        oc_per <= 14'h0050;
        target <= 12'h640;
        repeat (60 * MSC) @(posedge core_clk_in);
        running <= 1'b0;
        repeat (2 * MSC) @(posedge core_clk_in);
        running <= 1'b1;
        wait_flag(0, 1'b1, 79 * MSC, 82 * MSC + 2);
        @(posedge core_clk_in);
        target <= 12'h3e8;
        wait_flag(0, 1'b0, 99 * MSC, 102 * MSC);
        $display("test stop clears timer done");
        running <= 1'b0;
        toff    <= 1'b1;
        oc_per  <= 14'h0000;
        qualify(0, 50, 1600, 1000);
        toff    <= 1'b0;
        running <= 1'b1;
        $display("test offline tuning done");
        qualify(1, eff_zc(int'(zc_per)), 10, 100);
        for (int i = 0; i < 3; i++)
        begin
            zc_per  <= (i == 0) ? 10'h014 : 10'(($unsigned($random(seed)) % 200));
            running <= (i != 1);
            ton     <= (i == 1);
            @(posedge core_clk_in);
            qualify(1, eff_zc(int'(zc_per)), 49, 50);
        end
        $display("test zero current done");
        test_done();
    end
endmodule : tb_output_current_threshold_detect
